// >>> mtp_pkg.sv
package mtp_pkg;
   // array and address space
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int ROM_BYTES_DEF = 8192;
   localparam logic [15:0] SEC_ADDR = 16'hFFFF;
   // security register bit positions
   localparam int SEC_LOCK_BIT = 0;
   localparam int SEC_TBL_BIT = 1;
   localparam int SEC_ENC_BIT = 2;
   localparam logic [7:0] SEC_RESET = 8'hFF;
   localparam logic [7:0] ERASE_DATA = 8'hFF;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   // value shown for protected reads
   localparam logic [7:0] LOCKED_BYTE = 8'h00;
   // arbitrary identification values, not any real part
   localparam logic [7:0] MAKER_ID_DEF = 8'h5A;
   localparam logic [7:0] DEVICE_ID_DEF = 8'hA5;
   // program write pulse length, 100 ns at 8 ns clock
   localparam int PROG_TIME_NS = 100;
   localparam int CLK_PERIOD_NS = 8;
   localparam int PROG_CYC =
      (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // high-voltage pin level decoded by analogue front end
   typedef enum logic [1:0] {
      MTP_VPP_LOW, MTP_VPP_VIH, MTP_VPP_VCP, MTP_VPP_VEP
   } mtp_vpp_t;

   typedef struct packed {
      logic rst;
      logic ale;
      logic program_store_strobe_n;
      logic prog_ctrl_pin_zero;
      logic prog_ctrl_pin_one;
      logic prog_ctrl_pin_two;
      logic prog_ctrl_pin_three;
      logic chip_sel_n;
      logic out_en_n;
      mtp_vpp_t vpp;
   } mtp_pins_t;

   typedef enum logic [2:0] {
      MTP_OP_NONE, MTP_OP_READ, MTP_OP_PROG, MTP_OP_PVER,
      MTP_OP_ERASE, MTP_OP_EVER, MTP_OP_ID
   } mtp_op_t;

   // pin levels to operation, shared by decoder and its users
   function automatic mtp_op_t mtp_decode(input mtp_pins_t p,
                                          input logic a0);
      logic base;
      base = p.rst && !p.ale && p.program_store_strobe_n &&
             !p.prog_ctrl_pin_one && !p.prog_ctrl_pin_two &&
             !p.prog_ctrl_pin_three;
      mtp_decode = MTP_OP_NONE;
      if (base && !(p.chip_sel_n && p.out_en_n)) begin
         unique case ({p.prog_ctrl_pin_zero, p.chip_sel_n, p.out_en_n})
            3'b000: mtp_decode = (p.vpp == MTP_VPP_VIH) ?
                                 MTP_OP_READ : MTP_OP_NONE;
            3'b001: mtp_decode = (p.vpp == MTP_VPP_VCP) ?
                                 MTP_OP_PROG : MTP_OP_NONE;
            3'b010: mtp_decode = (p.vpp == MTP_VPP_VCP) ?
                                 MTP_OP_PVER : MTP_OP_NONE;
            3'b100: mtp_decode = (p.vpp == MTP_VPP_VIH) ?
                                 MTP_OP_ID : MTP_OP_NONE;
            3'b101: mtp_decode = (p.vpp == MTP_VPP_VEP && !a0) ?
                                 MTP_OP_ERASE : MTP_OP_NONE;
            3'b110: mtp_decode = (p.vpp == MTP_VPP_VEP) ?
                                 MTP_OP_EVER : MTP_OP_NONE;
            default: mtp_decode = MTP_OP_NONE;
         endcase
      end
   endfunction : mtp_decode
endpackage : mtp_pkg

// >>> mtp_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for a bus of pin levels
module mtp_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage is read by the second stage only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : mtp_sync

// >>> mtp_prog_port.sv
`timescale 1ns/100ps
module mtp_prog_port
   import mtp_pkg::*;
#(
   parameter int ROM_BYTES = ROM_BYTES_DEF,
   parameter logic [7:0] MAKER_ID = MAKER_ID_DEF,
   parameter logic [7:0] DEVICE_ID = DEVICE_ID_DEF
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire mtp_pkg::mtp_pins_t pins,
   input wire logic [7:0] addr_hi,
   input wire logic [7:0] addr_lo,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic cpu_fetch_external,
   input wire logic cpu_table_read,
   input wire logic [15:0] cpu_addr,
   output logic cpu_table_internal_ok,
   output logic [7:0] cpu_rom_data,
   output logic encrypt_en,
   output logic [7:0] enc_key
);
   import mtp_pkg::*;

   localparam int AW = $clog2(ROM_BYTES);
   localparam int PIN_W = $bits(mtp_pins_t) + 24;

   // a power of two keeps the address slice exact, and the top byte of
   // the space must stay free for the security register
   if (ROM_BYTES < 2 || ROM_BYTES > 65535 ||
       (ROM_BYTES & (ROM_BYTES - 1)) != 0) begin : g_bad_size
      $error("ROM_BYTES must be a power of two below 64K");
   end

   ////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic rst_meta_r;
   logic rst_sync_n;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_n <= rst_meta_r;
      end
   end

   // pins, address and data cross together, so one sample never mixes
   // the levels of two different selections
   logic [PIN_W-1:0] pin_sync;
   mtp_sync #(.W(PIN_W)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_sync_n),
      .d({pins, addr_hi, addr_lo, data_in}),
      .q(pin_sync)
   );

   mtp_pins_t p_s;
   wire [15:0] addr_s = pin_sync[23:8];
   wire [7:0] din_s = pin_sync[7:0];
   assign p_s = mtp_pins_t'(pin_sync[PIN_W-1:24]);

   ////////////////////////////////////////////////////////////////////
   // operation decode; anything off-table falls to none
   wire mtp_op_t op = mtp_decode(p_s, addr_s[0]);
   // the core loses the array while the reset pin holds the part in
   // programming mode, whatever selection stands on the other pins
   wire prog_mode = p_s.rst;
   wire is_sec = (addr_s == SEC_ADDR);
   wire in_array = (addr_s < 16'(ROM_BYTES));
   // the four selections that may turn port 0 around
   wire is_read_op = (op == MTP_OP_READ) || (op == MTP_OP_PVER) ||
                     (op == MTP_OP_EVER) || (op == MTP_OP_ID);

   ////////////////////////////////////////////////////////////////////
   // storage: the array and the security register
   logic [7:0] rom_mem [ROM_BYTES];
   logic [7:0] sec_r;
   logic [7:0] sec_nxt;
   logic [7:0] key_r;
   logic [7:0] prog_cnt_r;
   logic [7:0] prog_cnt_nxt;
   logic erase_done_r;
   logic [AW-1:0] erase_ptr_r;
   logic erasing_r;

   wire lock_on = !sec_r[SEC_LOCK_BIT];
   wire enc_on = !sec_r[SEC_ENC_BIT];

   // program only fires once per held selection, after a settle time;
   // a held pin pattern therefore never writes twice
   wire prog_go = (op == MTP_OP_PROG) &&
                  (prog_cnt_r == 8'(PROG_CYC - 1));
   // counter parks one past the write point while the selection holds
   assign prog_cnt_nxt = (op != MTP_OP_PROG) ? 8'h00 :
                         (prog_cnt_r == 8'(PROG_CYC)) ? prog_cnt_r :
                         prog_cnt_r + 8'h01;

   // bits can only clear by programming, set by erase
   assign sec_nxt = (erasing_r) ? SEC_RESET :
                    (prog_go && is_sec) ? (sec_r & din_s) :
                    sec_r;

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         sec_r <= SEC_RESET;
         prog_cnt_r <= 8'h00;
      end else begin
         sec_r <= sec_nxt;
         prog_cnt_r <= prog_cnt_nxt;
      end
   end

   // erase walks the array one byte per clock; a whole chip takes
   // ROM_BYTES cycles, cheaper than a wide clear port
   wire erase_req = (op == MTP_OP_ERASE) && (din_s == ERASE_DATA);
   // one sweep per held erase selection; done stays set until release
   wire erase_last = erasing_r && (erase_ptr_r == AW'(ROM_BYTES - 1));
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         erasing_r <= 1'b0;
         erase_ptr_r <= '0;
         erase_done_r <= 1'b0;
      end else if (!erase_req) begin
         erasing_r <= 1'b0;
         erase_ptr_r <= '0;
         erase_done_r <= 1'b0;
      end else begin
         erasing_r <= !erase_done_r && !erase_last;
         erase_done_r <= erase_done_r || erase_last;
         if (erasing_r) begin
            erase_ptr_r <= erase_ptr_r + AW'(1);
         end
      end
   end

   // array write: programming can only pull bits low
   always_ff @(posedge ref_clk) begin
      if (erasing_r) begin
         rom_mem[erase_ptr_r] <= BLANK_BYTE;
      end else if (prog_go && in_array) begin
         rom_mem[addr_s[AW-1:0]] <= rom_mem[addr_s[AW-1:0]] & din_s;
      end
   end

   // encryption key comes from the low array byte once enabled;
   // it trails a write to that byte by one clock
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         key_r <= 8'h00;
      end else begin
         key_r <= enc_on ? rom_mem[0] : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // programming-mode read path
   wire [7:0] arr_byte = in_array ? rom_mem[addr_s[AW-1:0]] : BLANK_BYTE;
   wire [7:0] raw_byte = is_sec ? sec_r : arr_byte;
   wire [7:0] id_byte = addr_s[0] ? DEVICE_ID : MAKER_ID;
   wire [7:0] read_byte = (op == MTP_OP_ID) ? id_byte : raw_byte;
   wire [7:0] enc_byte = (enc_on && op != MTP_OP_ID) ?
                         (read_byte ^ key_r) : read_byte;
   // lock masks last, so a locked part shows one fixed byte whatever
   // the key, and hides the ids as well
   wire [7:0] shown_byte = lock_on ? LOCKED_BYTE : enc_byte;

   // data held in a flop; the enable comes straight from the synchronised pins, one clock ahead of the data
   logic [7:0] data_out_r;
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         data_out_r <= 8'h00;
      end else begin
         data_out_r <= shown_byte;
      end
   end
   assign data_out = data_out_r;
   // gated by the internal reset so port 0 floats until the part is up
   assign data_oe = is_read_op && !p_s.out_en_n && rst_sync_n;

   ////////////////////////////////////////////////////////////////////
   // normal-mode table-read gate and code fetch
   wire tbl_free = sec_r[SEC_TBL_BIT];
   // external code reaching internal rom is refused when bit is 0
   assign cpu_table_internal_ok = !cpu_table_read || !cpu_fetch_external ||
                                  tbl_free;
   wire cpu_in = (cpu_addr < 16'(ROM_BYTES)) && !prog_mode;
   // registered so the core sees a clean byte one clock after its address
   logic [7:0] cpu_rom_r;
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cpu_rom_r <= 8'h00;
      end else begin
         cpu_rom_r <= cpu_in ? rom_mem[cpu_addr[AW-1:0]] : BLANK_BYTE;
      end
   end
   assign cpu_rom_data = cpu_rom_r;
   assign encrypt_en = enc_on;
   assign enc_key = key_r;
endmodule : mtp_prog_port

// >>> mtp_prog_port_asserts.sv
`timescale 1ns/100ps
// drive and decode checks at the programming port pins
module mtp_prog_port_asserts
   import mtp_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = MAKER_ID_DEF,
   parameter logic [7:0] DEVICE_ID = DEVICE_ID_DEF
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire mtp_pkg::mtp_pins_t pins,
   input wire logic [7:0] addr_lo,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic cpu_fetch_external,
   input wire logic cpu_table_internal_ok,
   input wire logic [7:0] cpu_rom_data
);
   logic [2:0] age_r;
   logic up, rd, rdv, id;
   // pins only count once internal reset and sync have both passed
   assign up = age_r == 3'h7;
   assign rd = pins.rst && !pins.ale && pins.program_store_strobe_n
      && !pins.prog_ctrl_pin_one && !pins.prog_ctrl_pin_two
      && !pins.prog_ctrl_pin_three && !pins.chip_sel_n && !pins.out_en_n;
   assign rdv = rd && !pins.prog_ctrl_pin_zero;
   assign id = rd && pins.prog_ctrl_pin_zero && pins.vpp == MTP_VPP_VIH;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) age_r <= 3'h0;
      else if (!up) age_r <= age_r + 3'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////
   property p_oe_off; pins.out_en_n [*3] |-> !data_oe; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("port 0 driven with oe high");
   property p_rd;
      (up && rdv && pins.vpp == MTP_VPP_VIH) [*3] |-> data_oe;
   endproperty
   a_rd: assert property (p_rd)
      else $error("read selection not driving port 0");
   property p_low;
      (up && rdv && pins.vpp == MTP_VPP_LOW) [*3] |-> !data_oe;
   endproperty
   a_low: assert property (p_low)
      else $error("port 0 driven with wrong vpp level");
   property p_mk;
      (up && id && !addr_lo[0]) [*5] |->
         data_out inside {MAKER_ID, LOCKED_BYTE};
   endproperty
   a_mk: assert property (p_mk)
      else $error("maker id wrong");
   property p_dv;
      (up && id && addr_lo[0]) [*5] |->
         data_out inside {DEVICE_ID, LOCKED_BYTE};
   endproperty
   a_dv: assert property (p_dv)
      else $error("device id wrong");
   property p_norm; (up && !pins.rst) [*3] |-> !data_oe; endproperty
   a_norm: assert property (p_norm)
      else $error("port 0 driven in normal mode");
   property p_tbl; !cpu_fetch_external |-> cpu_table_internal_ok; endproperty
   a_tbl: assert property (p_tbl)
      else $error("internal table read blocked");
   property p_cpu;
      (up && pins.rst) [*5] |-> cpu_rom_data == BLANK_BYTE;
   endproperty
   a_cpu: assert property (p_cpu)
      else $error("array visible to core in programming mode");
   c_rd: cover property ((up && rdv) [*3]);
   c_id: cover property ((up && id) [*5]);
   c_er: cover property (up && pins.vpp == MTP_VPP_VEP && pins.out_en_n);
endmodule : mtp_prog_port_asserts

bind mtp_prog_port mtp_prog_port_asserts #(
   .MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) mtp_prog_port_asserts_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins), .addr_lo(addr_lo),
   .data_out(data_out), .data_oe(data_oe),
   .cpu_fetch_external(cpu_fetch_external),
   .cpu_table_internal_ok(cpu_table_internal_ok),
   .cpu_rom_data(cpu_rom_data));

// >>> mtp_programmer_model.sv
`timescale 1ns/100ps
// programmer side: pin levels, address and data, moved at falling edges
module mtp_programmer_model (
   input wire logic ref_clk,
   output mtp_pkg::mtp_pins_t pins,
   output logic [7:0] addr_hi,
   output logic [7:0] addr_lo,
   output logic [7:0] data_in
);
   import mtp_pkg::*;
   ////////////////////////////////////////////////////////////
   // start inhibited: both selects high, so nothing can be written
   initial begin
      pins = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
               MTP_VPP_VIH};
      {addr_hi, addr_lo} = 16'h0000;
      data_in = 8'h00;
   end
   // one selection held for n cycles
   task automatic apply(input logic [2:0] s, input mtp_vpp_t v,
                        input logic [15:0] a, input logic [7:0] d,
                        input int n);
      @(negedge ref_clk);
      pins.rst = 1'b1;
      pins.ale = 1'b0;
      pins.program_store_strobe_n = 1'b1;
      {pins.prog_ctrl_pin_zero, pins.chip_sel_n, pins.out_en_n} = s;
      pins.vpp = v;
      {addr_hi, addr_lo} = a;
      // a released bus must not keep showing the last byte
      data_in = s[0] ? d : ~data_in;
      repeat (n) @(negedge ref_clk);
   endtask : apply
   // reset pin low hands the part back to the core
   task automatic normal(input int n);
      @(negedge ref_clk);
      pins.rst = 1'b0;
      repeat (n) @(negedge ref_clk);
   endtask : normal
endmodule : mtp_programmer_model

// >>> mtp_prog_port_tb.sv
`timescale 1ns/100ps
module mtp_prog_port_tb;
   import mtp_pkg::*;
   localparam logic [2:0] RD = 3'b000, PG = 3'b001, PV = 3'b010;
   localparam logic [2:0] ID = 3'b100, ER = 3'b101, EV = 3'b110;
   localparam logic [2:0] OFF = 3'b011;
   localparam mtp_vpp_t H = MTP_VPP_VIH, C = MTP_VPP_VCP, E = MTP_VPP_VEP;
   localparam int ROM_N = 16;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ext = 1'b0;
   logic tbl = 1'b0;
   logic [15:0] caddr = 16'h0000;
   mtp_pins_t pins;
   logic [7:0] ahi, alo, din, dout, crd, key;
   logic oe, tok, enc;
   int checks = 0;
   int fail_count = 0;
   always #4 ref_clk = ~ref_clk;
   // short array keeps the erase sweep brief
   mtp_prog_port #(.ROM_BYTES(ROM_N)) mtp_prog_port_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins), .addr_hi(ahi),
      .addr_lo(alo), .data_in(din), .data_out(dout), .data_oe(oe),
      .cpu_fetch_external(ext), .cpu_table_read(tbl), .cpu_addr(caddr),
      .cpu_table_internal_ok(tok), .cpu_rom_data(crd), .encrypt_en(enc),
      .enc_key(key));
   mtp_programmer_model mtp_programmer_model_i (.ref_clk(ref_clk),
      .pins(pins), .addr_hi(ahi), .addr_lo(alo), .data_in(din));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] s,
                      input logic [7:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic finish_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task automatic ap(input logic [2:0] s, input mtp_vpp_t v,
                     input logic [15:0] a, input logic [7:0] d, input int n);
      mtp_programmer_model_i.apply(s, v, a, d, n);
   endtask : ap
   // e holds expected drive enable above expected byte
   task automatic rd(input logic [2:0] s, input mtp_vpp_t v,
                     input logic [15:0] a, input logic [8:0] e);
      ap(s, v, a, 8'h00, 5);
      chk("data_oe", {7'h00, oe}, {7'h00, e[8]});
      if (e[8]) chk("data_out", dout, e[7:0]);
   endtask : rd
   // back to inhibit after each write so one hold gives one write
   task automatic pg(input logic [15:0] a, input logic [7:0] d);
      ap(PG, C, a, d, PROG_CYC + 4);
      ap(OFF, H, a, d, 3);
   endtask : pg
   // full-chip erase; the array starts unknown, so the run opens with it
   task automatic erase_all;
      ap(ER, E, 16'h0000, ERASE_DATA, ROM_N + 8);
      ap(OFF, E, 16'h0000, 8'hFF, 3);
   endtask : erase_all
   task automatic s_blank;
      rd(RD, H, 16'h0000, 9'h1FF);
      rd(RD, MTP_VPP_LOW, 16'h0000, 9'h000);
      rd(ID, H, 16'h0000, {1'b1, MAKER_ID_DEF});
      rd(ID, H, 16'h0001, {1'b1, DEVICE_ID_DEF});
   endtask : s_blank
   task automatic s_prog;
      pg(16'h0003, 8'h3C);
      rd(PV, C, 16'h0003, 9'h13C);
      pg(16'h0003, 8'hF0);
      rd(PV, C, 16'h0003, 9'h130);
      ap(OFF, C, 16'h0003, 8'h00, 20);
      rd(RD, H, 16'h0003, 9'h130);
      rd(PG, H, 16'h0003, 9'h000);
      // erase with a0 high is refused and leaves the array alone
      ap(ER, E, 16'h0001, ERASE_DATA, ROM_N + 8);
      ap(OFF, E, 16'h0001, 8'hFF, 3);
      rd(RD, H, 16'h0003, 9'h130);
   endtask : s_prog
   task automatic s_sec;
      pg(16'hFFFF, 8'hFD);
      rd(PV, C, 16'hFFFF, 9'h1FD);
      pg(16'hFFFF, 8'hFF);
      rd(RD, H, 16'hFFFF, 9'h1FD);
      caddr = 16'h0003;
      ext = 1'b1;
      tbl = 1'b1;
      mtp_programmer_model_i.normal(6);
      chk("cpu_rom_data", crd, 8'h30);
      chk("table_ok", {7'h00, tok}, 8'h00);
      chk("data_oe", {7'h00, oe}, 8'h00);
      caddr = 16'hFFFF;
      ext = 1'b0;
      mtp_programmer_model_i.normal(6);
      chk("cpu_rom_data", crd, 8'hFF);
      chk("table_ok", {7'h00, tok}, 8'h01);
      pg(16'hFFFF, 8'hFB);
      chk("encrypt_en", {7'h00, enc}, 8'h01);
      chk("enc_key", key, BLANK_BYTE);
      rd(RD, H, 16'h0003, 9'h1CF);
   endtask : s_sec
   task automatic s_lock;
      pg(16'hFFFF, 8'hFE);
      rd(RD, H, 16'h0003, 9'h100);
      rd(ID, H, 16'h0000, 9'h100);
   endtask : s_lock
   task automatic s_erase;
      erase_all();
      rd(EV, E, 16'h0003, 9'h1FF);
      for (int i = 0; i < ROM_N; i++) begin
         rd(EV, E, 16'(i), 9'h1FF);
      end
      rd(EV, E, 16'hFFFF, 9'h1FF);
      chk("encrypt_en", {7'h00, enc}, 8'h00);
      chk("enc_key", key, 8'h00);
      rd(ID, H, 16'h0001, {1'b1, DEVICE_ID_DEF});
   endtask : s_erase
   // hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (5) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge ref_clk);
      erase_all();
      s_blank();
      s_prog();
      s_sec();
      s_lock();
      s_erase();
      finish_test();
   end
endmodule : mtp_prog_port_tb
